/* File: hw/bsg_defs.svh */
// Timing counts, field widths and table sizes for the broadcast storm guard
`ifndef BSG_DEFS_SVH
`define BSG_DEFS_SVH
`define BSG_CLK_HZ          10000000
`define BSG_SEC_CYCLES      (`BSG_CLK_HZ * 1)
`define BSG_OFF_SEC         15
`define BSG_ON_SEC          5
`define BSG_TOTAL_SEC       120
`define BSG_THR_MAX         16'h3A20
`define BSG_THR_W           16
`define BSG_PORTS           24
`define BSG_UPLINKS         2
`define BSG_LOG_DEPTH       16
`endif

/* File: hw/bsg_pkg.sv */
// Types shared by the broadcast storm guard
package bsg_pkg;
    typedef enum logic [1:0] {
        BSG_ACT_NONE,
        BSG_ACT_PARTITION,
        BSG_ACT_TRAP,
        BSG_ACT_BOTH
    } bsg_action_e;
    typedef enum logic [1:0] {
        BSG_MON_ENABLED,
        BSG_MON_DISABLED,
        BSG_MON_INVALID
    } bsg_mon_e;
    typedef logic [15:0] bsg_cnt_t;
endpackage

/* File: hw/bsg_guard.sv */
// Broadcast storm detection and port partitioning for one hub
`timescale 1ns/10ps
`include "bsg_defs.svh"
module bsg_guard #(
    parameter int SEC_CYCLES = `BSG_SEC_CYCLES,
    parameter logic [7:0] HUB_ID = 8'h01
) (
    input  wire logic                         sys_clk_in,
    input  wire logic                         srst_in,
    input  wire logic [`BSG_PORTS-1:0]        port_bcast_in,
    input  wire logic [`BSG_UPLINKS-1:0]      uplink_bcast_in,
    input  wire logic                         aui_bcast_in,
    input  wire logic [`BSG_PORTS-1:0]        port_seg_in,
    input  wire logic                         cfg_seg_sel_in,
    input  wire logic                         cfg_wr_in,
    input  wire bsg_pkg::bsg_mon_e            cfg_mon_in,
    input  wire bsg_pkg::bsg_action_e         cfg_action_in,
    input  wire logic [`BSG_THR_W-1:0]        cfg_seg_thr_in,
    input  wire logic [`BSG_THR_W-1:0]        cfg_mod_thr_in,
    input  wire logic                         port_thr_wr_in,
    input  wire logic [4:0]                   port_thr_idx_in,
    input  wire logic [`BSG_THR_W-1:0]        port_thr_in,
    input  wire logic [3:0]                   log_rd_idx_in,
    output logic [`BSG_PORTS-1:0]             port_enable_out,
    output logic [`BSG_PORTS-1:0]             port_detected_out,
    output logic [1:0]                        seg_detected_out,
    output logic [`BSG_UPLINKS:0]             mod_detected_out,
    output logic                              trap_req_out,
    output logic [15:0]                       log_entry_out,
    output logic [4:0]                        log_count_out
);
    import bsg_pkg::*;

    localparam int NS = 2;
    localparam int NI = `BSG_PORTS + NS + `BSG_UPLINKS + 1;
    localparam int UP0 = `BSG_PORTS + NS;
    localparam int AUI = NI - 1;

    bsg_action_e             act [NS];
    bsg_action_e             next_act [NS];
    bsg_mon_e                mon [NS];
    bsg_mon_e                next_mon [NS];
    bsg_cnt_t                seg_thr [NS];
    bsg_cnt_t                next_seg_thr [NS];
    bsg_cnt_t                mod_thr [NS];
    bsg_cnt_t                next_mod_thr [NS];
    bsg_cnt_t                pthr [`BSG_PORTS];
    bsg_cnt_t                next_pthr [`BSG_PORTS];
    bsg_cnt_t                cnt [NI];
    bsg_cnt_t                next_cnt [NI];
    logic [NI-1:0]           ev;
    logic [NI-1:0]           storm;
    logic [NI-1:0]           armed;
    logic [31:0]             sec_cnt;
    logic [31:0]             next_sec_cnt;
    logic                    tick;
    logic [4:0]              off_sec [`BSG_PORTS];
    logic [4:0]              next_off_sec [`BSG_PORTS];
    logic [6:0]              tot_sec [`BSG_PORTS];
    logic [6:0]              next_tot_sec [`BSG_PORTS];
    logic [`BSG_PORTS-1:0]   part;
    logic [`BSG_PORTS-1:0]   next_part;
    logic [`BSG_PORTS-1:0]   next_port_enable;
    logic [`BSG_PORTS-1:0]   next_port_det;
    logic [1:0]              next_seg_det;
    logic [`BSG_UPLINKS:0]   next_mod_det;
    logic                    next_trap;
    logic [15:0]             log_mem [`BSG_LOG_DEPTH];
    logic [15:0]             next_log_mem [`BSG_LOG_DEPTH];
    logic [4:0]              next_log_count;
    logic [15:0]             next_log_entry;

    assign ev = {aui_bcast_in, uplink_bcast_in, 2'(0), port_bcast_in};
    assign tick = (sec_cnt == 32'(SEC_CYCLES - 1));

    // Configuration
    always_comb begin
        next_act = act;
        next_mon = mon;
        next_seg_thr = seg_thr;
        next_mod_thr = mod_thr;
        next_pthr = pthr;
        if (cfg_wr_in) begin
            if (cfg_mon_in == BSG_MON_INVALID) begin
                next_mon[cfg_seg_sel_in] = BSG_MON_DISABLED;
                next_act[cfg_seg_sel_in] = BSG_ACT_NONE;
                next_seg_thr[cfg_seg_sel_in] = `BSG_THR_MAX;
                next_mod_thr[cfg_seg_sel_in] = `BSG_THR_MAX;
            end else begin
                next_mon[cfg_seg_sel_in] = cfg_mon_in;
                next_act[cfg_seg_sel_in] = cfg_action_in;
                // Out-of-range thresholds saturate rather than wrap
                next_seg_thr[cfg_seg_sel_in] = (cfg_seg_thr_in > `BSG_THR_MAX) ?
                                               `BSG_THR_MAX : cfg_seg_thr_in;
                next_mod_thr[cfg_seg_sel_in] = (cfg_mod_thr_in > `BSG_THR_MAX) ?
                                               `BSG_THR_MAX : cfg_mod_thr_in;
            end
        end
        if (port_thr_wr_in && port_thr_idx_in < 5'(`BSG_PORTS)) begin
            next_pthr[port_thr_idx_in] = (port_thr_in > `BSG_THR_MAX) ?
                                         `BSG_THR_MAX : port_thr_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            act <= '{default: BSG_ACT_NONE};
            mon <= '{default: BSG_MON_DISABLED};
            seg_thr <= '{default: `BSG_THR_MAX};
            mod_thr <= '{default: `BSG_THR_MAX};
            pthr <= '{default: `BSG_THR_MAX};
        end else begin
            act <= next_act;
            mon <= next_mon;
            seg_thr <= next_seg_thr;
            mod_thr <= next_mod_thr;
            pthr <= next_pthr;
        end
    end

    // Per-item counting and threshold compare
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_item
            logic           evt;
            bsg_cnt_t       thr;
            logic           seg;
            if (gi < `BSG_PORTS) begin : g_port
                // Partitioned ports are still counted
                assign seg = port_seg_in[gi];
                assign evt = ev[gi];
                assign thr = pthr[gi];
            end else if (gi < UP0) begin : g_seg
                assign seg = 1'(gi - `BSG_PORTS);
                assign evt = |(port_bcast_in & ((gi == `BSG_PORTS) ?
                              ~port_seg_in : port_seg_in));
                assign thr = seg_thr[gi - `BSG_PORTS];
            end else if (gi < AUI) begin : g_up
                assign seg = 1'b1;
                assign evt = ev[gi];
                assign thr = mod_thr[1];
            end else begin : g_aui
                assign seg = 1'b0;
                assign evt = ev[gi];
                assign thr = mod_thr[0];
            end
            assign armed[gi] = (mon[seg] == BSG_MON_ENABLED);
            // Count over a one-second window is the rate
            assign storm[gi] = tick && armed[gi] && (cnt[gi] > thr);
            always_comb begin
                next_cnt[gi] = cnt[gi];
                if (tick) begin
                    next_cnt[gi] = bsg_cnt_t'(evt);
                end else if (evt && cnt[gi] != 16'hFFFF) begin
                    next_cnt[gi] = cnt[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    // Storm reaction and partition cycling
    always_comb begin
        next_sec_cnt = tick ? 32'h0 : sec_cnt + 32'h1;
        next_part = part;
        next_off_sec = off_sec;
        next_tot_sec = tot_sec;
        next_port_det = port_detected_out;
        next_seg_det = seg_detected_out;
        next_mod_det = mod_detected_out;
        next_trap = 1'b0;
        next_log_mem = log_mem;
        next_log_count = log_count_out;
        next_port_enable = port_enable_out;
        next_seg_det |= storm[UP0-1:`BSG_PORTS];
        next_mod_det |= storm[AUI:UP0];
        for (int s = 0; s < NS; s++) begin
            if (storm[`BSG_PORTS + s] && act[s][1]) begin
                next_trap = 1'b1;
            end
        end
        for (int u = 0; u <= `BSG_UPLINKS; u++) begin
            if (storm[UP0 + u] && act[(u == `BSG_UPLINKS) ? 0 : 1][1]) begin
                next_trap = 1'b1;
            end
        end
        for (int p = 0; p < `BSG_PORTS; p++) begin
            // Phase runs on while the storm persists, so off/on cycling never stalls
            if (part[p] && tick) begin
                next_off_sec[p] = (off_sec[p] == 5'(`BSG_OFF_SEC + `BSG_ON_SEC - 1)) ?
                                  5'd0 : off_sec[p] + 5'd1;
                next_tot_sec[p] = tot_sec[p] + 7'd1;
                // Quiet window during an on phase ends the partition
                if ((!storm[p] && off_sec[p] >= 5'(`BSG_OFF_SEC)) ||
                    tot_sec[p] == 7'(`BSG_TOTAL_SEC - 1)) begin
                    next_part[p] = 1'b0;
                end
            end
            if (storm[p]) begin
                next_port_det[p] = 1'b1;
                if (act[port_seg_in[p]][1]) begin
                    next_trap = 1'b1;
                end
                if (act[port_seg_in[p]][0] && !part[p]) begin
                    next_part[p] = 1'b1;
                    next_off_sec[p] = 5'd0;
                    next_tot_sec[p] = 7'd0;
                end
                if (next_log_count < 5'(`BSG_LOG_DEPTH)) begin
                    next_log_mem[next_log_count[3:0]] = {HUB_ID, 3'b000, 5'(p + 1)};
                    next_log_count = next_log_count + 5'd1;
                end
            end
            next_port_enable[p] = !next_part[p] ||
                                  (next_off_sec[p] >= 5'(`BSG_OFF_SEC));
        end
        next_log_entry = log_mem[log_rd_idx_in];
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sec_cnt <= 32'h0;
            cnt <= '{default: 16'h0000};
            part <= '0;
            off_sec <= '{default: 5'd0};
            tot_sec <= '{default: 7'd0};
            port_enable_out <= '1;
            port_detected_out <= '0;
            seg_detected_out <= '0;
            mod_detected_out <= '0;
            trap_req_out <= 1'b0;
            log_mem <= '{default: 16'h0000};
            log_count_out <= 5'd0;
            log_entry_out <= 16'h0000;
        end else begin
            sec_cnt <= next_sec_cnt;
            cnt <= next_cnt;
            part <= next_part;
            off_sec <= next_off_sec;
            tot_sec <= next_tot_sec;
            port_enable_out <= next_port_enable;
            port_detected_out <= next_port_det;
            seg_detected_out <= next_seg_det;
            mod_detected_out <= next_mod_det;
            trap_req_out <= next_trap;
            log_mem <= next_log_mem;
            log_count_out <= next_log_count;
            log_entry_out <= next_log_entry;
        end
    end
endmodule

/* File: test/bsg_guard_monitor.sv */
// Port-level assertion checker for the broadcast storm guard
`timescale 1ns/10ps
`include "bsg_defs.svh"
module bsg_guard_monitor #(
    parameter int SEC_CYCLES = 100
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  srst_in,
    input  wire logic [`BSG_PORTS-1:0] port_enable_out,
    input  wire logic [`BSG_PORTS-1:0] port_detected_out,
    input  wire logic [1:0]            seg_detected_out,
    input  wire logic [`BSG_UPLINKS:0] mod_detected_out,
    input  wire logic                  trap_req_out,
    input  wire logic [4:0]            log_count_out
);
    localparam int OFF_LEN = SEC_CYCLES * `BSG_OFF_SEC;
    // Low-run length of port 1, too long for a repetition
    int low_cnt;
    int next_low_cnt;
    always_comb begin
        next_low_cnt = port_enable_out[0] ? 0 : low_cnt + 1;
    end
    always_ff @(posedge sys_clk_in) begin
        low_cnt <= srst_in ? 0 : next_low_cnt;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_part_start;
        $fell(port_enable_out[0]);
    endsequence
    sequence s_part_hold;
        !port_enable_out[0] [*8];
    endsequence
    AST_PART_HOLDS: assert property (s_part_start |-> port_detected_out[0] ##1 s_part_hold)
        else $error("partitioned port not held off");
    AST_OFF_LEN: assert property ($rose(port_enable_out[0]) && low_cnt != 0 |-> low_cnt == OFF_LEN)
        else $error("partition off time wrong");
    AST_TRAP_PULSE: assert property (trap_req_out |=> !trap_req_out)
        else $error("trap request longer than one cycle");
    AST_TRAP_CAUSE: assert property (trap_req_out |-> |{port_detected_out, seg_detected_out, mod_detected_out})
        else $error("trap without detection");
    AST_DET_STICKY: assert property (!$past(srst_in) |-> ($past(port_detected_out) & ~port_detected_out) == '0)
        else $error("port detection flag cleared");
    AST_FLAG_STICKY: assert property (!$past(srst_in) |-> ($past({seg_detected_out, mod_detected_out}) & ~{seg_detected_out, mod_detected_out}) == '0)
        else $error("segment or module flag cleared");
    AST_EN_NEEDS_DET: assert property (!$past(srst_in) |-> ($past(port_enable_out) & ~port_enable_out & ~port_detected_out) == '0)
        else $error("port disabled without detection");
    AST_LOG_MONO: assert property (!$past(srst_in) |-> log_count_out >= $past(log_count_out) && log_count_out <= 5'h10)
        else $error("storm list count went back or overflowed");
endmodule

bind bsg_guard bsg_guard_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon_u (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .port_enable_out(port_enable_out),
    .port_detected_out(port_detected_out), .seg_detected_out(seg_detected_out),
    .mod_detected_out(mod_detected_out), .trap_req_out(trap_req_out),
    .log_count_out(log_count_out)
);

/* File: test/bsg_guard_tb.sv */
// Self-checking random testbench for the broadcast storm guard
`timescale 1ns/10ps
`include "bsg_defs.svh"
module bsg_guard_tb;
    import bsg_pkg::*;
    localparam int SEC = 100;
    localparam logic [7:0] HUB = 8'h5A;  // Arbitrary hub number
    logic                    sys_clk_in, srst_in, cfg_seg_sel_in, cfg_wr_in, aui_bcast_in;
    logic                    port_thr_wr_in, trap_req_out;
    logic [`BSG_PORTS-1:0]   port_bcast_in, port_enable_out, port_detected_out, port_seg_in;
    logic [`BSG_UPLINKS-1:0] uplink_bcast_in;
    logic [`BSG_UPLINKS:0]   mod_detected_out;
    logic [1:0]              seg_detected_out;
    logic [`BSG_THR_W-1:0]   cfg_seg_thr_in, cfg_mod_thr_in, port_thr_in;
    logic [4:0]              port_thr_idx_in, log_count_out;
    logic [3:0]              log_rd_idx_in;
    logic [15:0]             log_entry_out;
    bsg_mon_e                cfg_mon_in;
    bsg_action_e             cfg_action_in;
    logic [26:0]             mask_a, mask_b, ev;
    int                      cyc, k, n, d, traps, t0, mismatches, tests_run;
    integer                  seed;
    bsg_guard #(.SEC_CYCLES(SEC), .HUB_ID(HUB)) dut_u (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .port_bcast_in(port_bcast_in),
        .uplink_bcast_in(uplink_bcast_in), .aui_bcast_in(aui_bcast_in),
        .port_seg_in(port_seg_in), .cfg_seg_sel_in(cfg_seg_sel_in), .cfg_wr_in(cfg_wr_in),
        .cfg_mon_in(cfg_mon_in), .cfg_action_in(cfg_action_in),
        .cfg_seg_thr_in(cfg_seg_thr_in), .cfg_mod_thr_in(cfg_mod_thr_in),
        .port_thr_wr_in(port_thr_wr_in), .port_thr_idx_in(port_thr_idx_in),
        .port_thr_in(port_thr_in), .log_rd_idx_in(log_rd_idx_in),
        .port_enable_out(port_enable_out), .port_detected_out(port_detected_out),
        .seg_detected_out(seg_detected_out), .mod_detected_out(mod_detected_out),
        .trap_req_out(trap_req_out), .log_entry_out(log_entry_out),
        .log_count_out(log_count_out)
    );
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) cyc <= srst_in ? 0 : cyc + 1;
    always @(negedge sys_clk_in) if (trap_req_out === 1'b1) traps++;
    // Bursts sit mid-window so a tick offset of a few cycles cannot split them
    always @(posedge sys_clk_in) begin
        #10;
        ev = (cyc % SEC >= 20 && cyc % SEC < 20 + k) ? mask_a : '0;
        if (cyc % SEC >= 20 && cyc % SEC < 19 + k)
            ev = ev | mask_b;
        {aui_bcast_in, uplink_bcast_in, port_bcast_in} = ev;
    end
    function automatic logic storm(input int cnt, input int thr);
        return cnt > thr;
    endfunction
    function automatic logic [15:0] entry(input logic [4:0] port_no);
        return {HUB, 3'h0, port_no};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cfg(input logic sel, input bsg_mon_e mon, input bsg_action_e act);
        cfg_seg_sel_in = sel;
        cfg_mon_in = mon;
        cfg_action_in = act;
        cfg_seg_thr_in = `BSG_THR_MAX;
        cfg_mod_thr_in = n[15:0];
        cfg_wr_in = 1'b1;
        @(posedge sys_clk_in);
        #10 cfg_wr_in = 1'b0;
        @(posedge sys_clk_in);
        #10;
    endtask
    task automatic pthr(input logic [4:0] idx);
        port_thr_idx_in = idx;
        port_thr_in = n[15:0];
        port_thr_wr_in = 1'b1;
        @(posedge sys_clk_in);
        #10 port_thr_wr_in = 1'b0;
        @(posedge sys_clk_in);
        #10;
    endtask
    task automatic wait_cyc(input int t);
        while (cyc < t) @(negedge sys_clk_in);
    endtask
    initial begin
        seed = 32'h2409;
        n = 2 + ($random(seed) & 7);
        k = 0;
        mask_a = '0;
        mask_b = '0;
        {aui_bcast_in, uplink_bcast_in, port_bcast_in} = '0;
        srst_in = 1'b1;
        {cfg_wr_in, port_thr_wr_in, cfg_seg_sel_in} = '0;
        cfg_mon_in = BSG_MON_DISABLED;
        cfg_action_in = BSG_ACT_NONE;
        {cfg_seg_thr_in, cfg_mod_thr_in, port_thr_idx_in, port_thr_in, log_rd_idx_in} = '0;
        port_seg_in = '1;
        repeat (20) @(posedge sys_clk_in);
        #10 srst_in = 1'b0;
        check(port_enable_out, 24'hFFFFFF);
        check(log_count_out, 5'h00);
        cfg(1'b0, BSG_MON_DISABLED, BSG_ACT_TRAP);
        cfg(1'b1, BSG_MON_ENABLED, BSG_ACT_BOTH);
        pthr(5'd0);
        pthr(5'd1);
        k = n + 1;
        mask_a = 27'h4000001;
        mask_b = 27'h0000002;
        d = 0;
        while (port_detected_out[0] !== 1'b1 && d < 3 * SEC) begin
            @(negedge sys_clk_in);
            d++;
        end
        d = cyc;
        mask_a = 27'h1;
        @(negedge sys_clk_in);
        check(port_detected_out, {22'h0, storm(n, n), storm(n + 1, n)});
        check(mod_detected_out, 3'h0);
        check(port_enable_out, 24'hFFFFFE);
        check(traps, 1);
        check(log_count_out, 5'h01);
        check(log_entry_out, entry(5'd1));
        wait_cyc(d + 15 * SEC + 50);
        check(port_enable_out[0], 1'b1);
        wait_cyc(d + 20 * SEC + 50);
        check(port_enable_out[0], 1'b0);
        mask_a = '0;
        wait_cyc(d + 35 * SEC + 50);
        check(port_enable_out[0], 1'b1);
        wait_cyc(d + 40 * SEC + 50);
        check(port_enable_out, 24'hFFFFFF);
        mask_a = 27'h1000000;
        mask_b = 27'h2000000;
        wait_cyc(cyc + 2 * SEC);
        check(mod_detected_out, {1'b0, storm(n, n), storm(n + 1, n)});
        mask_a = '0;
        mask_b = '0;
        cfg(1'b0, BSG_MON_ENABLED, BSG_ACT_TRAP);
        wait_cyc(cyc + 2 * SEC);
        t0 = traps;
        mask_a = 27'h4000000;
        wait_cyc(cyc + 2 * SEC);
        check(mod_detected_out[2], 1'b1);
        check(traps > t0, 1'b1);
        check(port_enable_out, 24'hFFFFFF);
        cfg(1'b0, BSG_MON_INVALID, BSG_ACT_TRAP);
        wait_cyc(cyc + SEC);
        t0 = traps;
        wait_cyc(cyc + 2 * SEC);
        check(traps, t0);
        log_rd_idx_in = 4'h1;
        repeat (2) @(negedge sys_clk_in);
        check(log_entry_out, entry(5'd1));
        check(log_count_out, 5'h10);
        conclude();
    end
    initial begin
        repeat (70 * SEC) @(posedge sys_clk_in);
        mismatches++;
        conclude();
    end
endmodule
